// file: design/switch_tag_drop_pkg.sv
package switch_tag_drop_pkg;

  // ==========================================================================
  // register indices (byte address is four times the index)
  localparam logic [13:0] IDX_HOST_TAG  = 14'h1C13;
  localparam logic [13:0] IDX_PORT1_TAG = 14'h1C14;
  localparam logic [13:0] IDX_PORT2_TAG = 14'h1C15;
  localparam logic [13:0] IDX_HOST_CNT  = 14'h1C16;
  localparam logic [13:0] IDX_PORT1_CNT = 14'h1C17;
  localparam logic [13:0] IDX_PORT2_CNT = 14'h1C18;
  localparam logic [13:0] IDX_MASK      = 14'h1C20;
  localparam logic [13:0] IDX_PENDING   = 14'h1C21;

  localparam int NUM_PORTS = 3;
  localparam int ADDR_W    = 16;

  // ==========================================================================
  // default tag fields
  localparam int          VID_LSB = 0;
  localparam int          VID_W   = 12;
  localparam int          PRI_LSB = 12;
  localparam int          PRI_W   = 3;
  localparam int          TAG_W   = 15;
  localparam logic [14:0] TAG_RST = 15'h0000;

  // ==========================================================================
  // counters and mask
  localparam logic [31:0] CNT_RST  = 32'h0000_0000;
  localparam logic [31:0] CNT_MAX  = 32'hFFFF_FFFF;
  localparam logic        MASK_RST = 1'b1;
  localparam int          MASK_BIT = 0;

  // ==========================================================================
  // pending status layout
  localparam int          PEND_W        = 14;
  localparam logic [13:0] PEND_RST      = 14'h0000;
  localparam int          A_VALID       = 0;
  localparam int          A_SRC_LSB     = 1;
  localparam int          A_REASON_LSB  = 3;
  localparam int          B_VALID       = 7;
  localparam int          B_SRC_LSB     = 8;
  localparam int          B_REASON_LSB  = 10;

endpackage : switch_tag_drop_pkg

// file: design/drop_if.sv
`timescale 1ns/1ps
interface drop_cnt_if;
  logic        inc;
  logic        clr;
  logic [31:0] value;
  modport ctl (output inc, output clr, input value);
  modport cnt (input inc, input clr, output value);
endinterface : drop_cnt_if

interface drop_pend_if;
  logic        evt;
  logic [3:0]  reason;
  logic [1:0]  src;
  logic        clr;
  logic [13:0] status;
  modport ctl   (output evt, output reason, output src, output clr, input status);
  modport store (input evt, input reason, input src, input clr, output status);
endinterface : drop_pend_if

// file: design/rate_drop_counter.sv
`timescale 1ns/1ps
module rate_drop_counter (
  input wire logic clk,
  input wire logic resetn,
  drop_cnt_if.cnt  cnt
);

  function automatic logic [31:0] sat_inc(input logic [31:0] v);
    sat_inc = (v == switch_tag_drop_pkg::CNT_MAX) ? v : v + 32'h0000_0001;
  endfunction : sat_inc

  // clear and a same-cycle drop leave a count of one, so no drop is lost
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
      cnt.value <= switch_tag_drop_pkg::CNT_RST;
    else if (cnt.clr)
      cnt.value <= cnt.inc ? 32'h0000_0001 : switch_tag_drop_pkg::CNT_RST;
    else if (cnt.inc)
      cnt.value <= sat_inc(cnt.value);
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);

  cnt_step_a: assert property (
    cnt.inc && !cnt.clr && cnt.value != switch_tag_drop_pkg::CNT_MAX
    |=> cnt.value == $past(cnt.value) + 32'h0000_0001)
    else $error("drop counter did not step");
  cnt_saturate_a: assert property (
    cnt.value == switch_tag_drop_pkg::CNT_MAX && !cnt.clr
    |=> cnt.value == switch_tag_drop_pkg::CNT_MAX)
    else $error("drop counter wrapped");

endmodule : rate_drop_counter

// file: design/drop_pending_status.sv
`timescale 1ns/1ps
module drop_pending_status (
  input wire logic   clk,
  input wire logic   resetn,
  drop_pend_if.store pend
);

  logic [13:0] status_next;

  // a drop fills set A first, then B; with both full further drops are not
  // recorded until software reads. a drop in the read cycle lands after the clear.
  always_comb
  begin
    status_next = pend.clr ? switch_tag_drop_pkg::PEND_RST : pend.status;
    if (pend.evt)
    begin
      if (!status_next[switch_tag_drop_pkg::A_VALID])
      begin
        status_next[switch_tag_drop_pkg::A_VALID] = 1'b1;
        status_next[switch_tag_drop_pkg::A_SRC_LSB +: 2] = pend.src;
        status_next[switch_tag_drop_pkg::A_REASON_LSB +: 4] = pend.reason;
      end
      else if (!status_next[switch_tag_drop_pkg::B_VALID])
      begin
        status_next[switch_tag_drop_pkg::B_VALID] = 1'b1;
        status_next[switch_tag_drop_pkg::B_SRC_LSB +: 2] = pend.src;
        status_next[switch_tag_drop_pkg::B_REASON_LSB +: 4] = pend.reason;
      end
    end
  end

  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
      pend.status <= switch_tag_drop_pkg::PEND_RST;
    else
      pend.status <= status_next;
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);

  pend_fill_a: assert property (
    pend.evt && (pend.clr || !pend.status[switch_tag_drop_pkg::A_VALID])
    |=> pend.status[switch_tag_drop_pkg::A_VALID]
        && pend.status[switch_tag_drop_pkg::A_REASON_LSB +: 4] == $past(pend.reason)
        && pend.status[switch_tag_drop_pkg::A_SRC_LSB +: 2] == $past(pend.src))
    else $error("pending set A not filled");
  pend_clear_a: assert property (
    pend.clr && !pend.evt |=> pend.status == switch_tag_drop_pkg::PEND_RST)
    else $error("pending status not cleared on read");

endmodule : drop_pending_status

// file: design/switch_tag_drop_regs.sv
// Chosen here: register access over APB.
`timescale 1ns/1ps
module switch_tag_drop_regs (
  input  wire logic                   clk,
  input  wire logic                   resetn,
  // ==========================================================================
  // apb slave
  input  wire logic                   psel,
  input  wire logic                   penable,
  input  wire logic                   pwrite,
  input  wire logic [15:0]            paddr,
  input  wire logic [31:0]            pwdata,
  input  wire logic [3:0]             pstrb,
  output logic      [31:0]            prdata,
  output logic                        pready,
  output logic                        pslverr,
  // ==========================================================================
  // drop events from the buffer manager datapath
  input  wire logic [2:0]             rate_drop_evt,
  input  wire logic                   drop_evt,
  input  wire logic [3:0]             drop_reason,
  input  wire logic [1:0]             drop_src,
  // ==========================================================================
  // egress tagging defaults and interrupt
  output logic      [2:0][11:0]       default_vid,
  output logic      [2:0][2:0]        default_pri,
  output logic                        drop_irq
);

  localparam logic [13:0] IDX_TAG [3] = '{switch_tag_drop_pkg::IDX_HOST_TAG,
                                          switch_tag_drop_pkg::IDX_PORT1_TAG,
                                          switch_tag_drop_pkg::IDX_PORT2_TAG};
  localparam logic [13:0] IDX_CNT [3] = '{switch_tag_drop_pkg::IDX_HOST_CNT,
                                          switch_tag_drop_pkg::IDX_PORT1_CNT,
                                          switch_tag_drop_pkg::IDX_PORT2_CNT};

  logic [2:0][14:0] tag_reg;
  logic             mask_reg;
  logic             irq_reg;
  logic [31:0]      prdata_reg;
  logic             pready_reg;
  logic             pslverr_reg;
  logic [31:0]      rd_next;
  logic             dec_err;
  logic [2:0]       tag_hit;
  logic [2:0]       cnt_hit;
  logic             mask_hit;
  logic             pend_hit;
  logic             setup;
  logic             access;
  logic [13:0]      idx;
  logic [31:0]      cnt_value [3];
  logic             pend_any;

  drop_pend_if pend ();

  function automatic logic [31:0] lane_merge(input logic [31:0] old_v,
                                             input logic [31:0] new_v,
                                             input logic [3:0]  strb);
    for (int b = 0; b < 4; b++)
      lane_merge[b*8 +: 8] = strb[b] ? new_v[b*8 +: 8] : old_v[b*8 +: 8];
  endfunction : lane_merge

  // ==========================================================================
  // apb decode
  assign setup  = psel && !penable;
  assign access = psel && penable && pready_reg;
  assign idx    = paddr[15:2];

  always_comb
  begin
    rd_next  = 32'h0000_0000;
    dec_err  = 1'b1;
    tag_hit  = 3'h0;
    cnt_hit  = 3'h0;
    mask_hit = 1'b0;
    pend_hit = 1'b0;
    if (paddr[1:0] != 2'h0)
      dec_err = 1'b1;
    else if (idx == switch_tag_drop_pkg::IDX_MASK)
    begin
      mask_hit = 1'b1;
      dec_err  = 1'b0;
      rd_next[switch_tag_drop_pkg::MASK_BIT] = mask_reg;
    end
    else if (idx == switch_tag_drop_pkg::IDX_PENDING)
    begin
      pend_hit = 1'b1;
      dec_err  = 1'b0;
      rd_next[switch_tag_drop_pkg::PEND_W-1:0] = pend.status;
    end
    else
    begin
      for (int p = 0; p < switch_tag_drop_pkg::NUM_PORTS; p++)
      begin
        if (idx == IDX_TAG[p])
        begin
          tag_hit[p] = 1'b1;
          dec_err    = 1'b0;
          rd_next[switch_tag_drop_pkg::TAG_W-1:0] = tag_reg[p];
        end
        else if (idx == IDX_CNT[p])
        begin
          cnt_hit[p] = 1'b1;
          dec_err    = 1'b0;
          rd_next    = cnt_value[p];
        end
      end
    end
  end

  // ==========================================================================
  // apb answer: data and side effects are taken at the setup edge, so the
  // value returned and the clear of a read-to-clear register are atomic
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      prdata_reg  <= 32'h0000_0000;
      pready_reg  <= 1'b0;
      pslverr_reg <= 1'b0;
    end
    else
    begin
      pready_reg <= setup;
      if (setup)
      begin
        prdata_reg  <= pwrite ? 32'h0000_0000 : rd_next;
        pslverr_reg <= dec_err;
      end
      else if (access)
        pslverr_reg <= 1'b0;
    end
  end

  // ==========================================================================
  // default tag registers
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
      tag_reg <= {3{switch_tag_drop_pkg::TAG_RST}};
    else if (access && pwrite)
    begin
      for (int p = 0; p < switch_tag_drop_pkg::NUM_PORTS; p++)
        if (tag_hit[p])
          tag_reg[p] <= 15'(lane_merge({17'h0_0000, tag_reg[p]}, pwdata, pstrb));
    end
  end

  always_comb
  begin
    for (int p = 0; p < switch_tag_drop_pkg::NUM_PORTS; p++)
    begin
      default_vid[p] = tag_reg[p][switch_tag_drop_pkg::VID_LSB +: switch_tag_drop_pkg::VID_W];
      default_pri[p] = tag_reg[p][switch_tag_drop_pkg::PRI_LSB +: switch_tag_drop_pkg::PRI_W];
    end
  end

  // ==========================================================================
  // interrupt mask; it only gates the output, never the pending store
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
      mask_reg <= switch_tag_drop_pkg::MASK_RST;
    else if (access && pwrite && mask_hit && pstrb[0])
      mask_reg <= pwdata[switch_tag_drop_pkg::MASK_BIT];
  end

  assign pend_any = pend.status[switch_tag_drop_pkg::A_VALID]
                 || pend.status[switch_tag_drop_pkg::B_VALID];

  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
      irq_reg <= 1'b0;
    else
      irq_reg <= pend_any && !mask_reg;
  end

  // ==========================================================================
  // counters and pending store
  genvar g;
  generate
    for (g = 0; g < switch_tag_drop_pkg::NUM_PORTS; g++)
    begin : g_cnt
      drop_cnt_if cnt ();
      assign cnt.inc      = rate_drop_evt[g];
      assign cnt.clr      = setup && !pwrite && cnt_hit[g];
      assign cnt_value[g] = cnt.value;
      rate_drop_counter u_cnt (
        .clk    (clk),
        .resetn (resetn),
        .cnt    (cnt)
      );
    end
  endgenerate

  assign pend.evt    = drop_evt;
  assign pend.reason = drop_reason;
  assign pend.src    = drop_src;
  assign pend.clr    = setup && !pwrite && pend_hit;

  drop_pending_status u_pend (
    .clk    (clk),
    .resetn (resetn),
    .pend   (pend)
  );

  assign prdata   = prdata_reg;
  assign pready   = pready_reg;
  assign pslverr  = pslverr_reg;
  assign drop_irq = irq_reg;

  // ==========================================================================
  // checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);

  vid_write_a: assert property (
    access && pwrite && tag_hit[1] && pstrb == 4'hF
    |=> default_vid[1] == $past(pwdata[11:0]))
    else $error("default vlan id not written");
  pri_write_a: assert property (
    access && pwrite && tag_hit[2] && pstrb == 4'hF
    |=> default_pri[2] == $past(pwdata[14:12]))
    else $error("default priority not written");
  cnt_read_clear_a: assert property (
    setup && !pwrite && cnt_hit[0] && !rate_drop_evt[0]
    |=> pready && prdata == $past(cnt_value[0]) && cnt_value[0] == 32'h0000_0000)
    else $error("drop counter read did not return and clear");
  irq_masked_a: assert property (
    mask_reg |=> !drop_irq)
    else $error("interrupt passed while masked");
  mask_keeps_status_a: assert property (
    access && pwrite && mask_hit && !drop_evt
    |=> pend.status == $past(pend.status))
    else $error("mask write altered pending status");
  irq_raise_a: assert property (
    pend_any && !mask_reg |=> drop_irq)
    else $error("interrupt not raised");
  apb_ready_a: assert property (
    setup |=> pready ##1 !pready)
    else $error("apb answer not one cycle");

  read_cnt_c: cover property (setup && !pwrite && |cnt_hit ##1 access);
  irq_fire_c: cover property (!drop_irq ##1 drop_irq);
  both_sets_c: cover property (pend.status[switch_tag_drop_pkg::B_VALID]);
  bad_addr_c: cover property (access && pslverr);

endmodule : switch_tag_drop_regs

// file: tb/switch_port_default_tag_drop_regs_bench.sv
`timescale 1ns/1ps
module switch_port_default_tag_drop_regs_bench;
  logic              clk;
  logic              resetn;
  logic              psel;
  logic              penable;
  logic              pwrite;
  logic [15:0]       paddr;
  logic [31:0]       pwdata;
  logic [3:0]        pstrb;
  logic [31:0]       prdata;
  logic              pready;
  logic              pslverr;
  logic [2:0]        rate_drop_evt;
  logic              drop_evt;
  logic [3:0]        drop_reason;
  logic [1:0]        drop_src;
  logic [2:0][11:0]  default_vid;
  logic [2:0][2:0]   default_pri;
  logic              drop_irq;
  int                err_count;
  int                compares;
  int                n;
  logic [31:0]       rd;
  logic              er;
  logic [31:0]       d;
  logic [31:0]       cnt_exp [3];
  logic [2:0]        m;
  logic [3:0]        r1;
  logic [3:0]        r2;
  logic [1:0]        s1;
  logic [1:0]        s2;

  switch_tag_drop_regs DUT (
    .clk           (clk),
    .resetn        (resetn),
    .psel          (psel),
    .penable       (penable),
    .pwrite        (pwrite),
    .paddr         (paddr),
    .pwdata        (pwdata),
    .pstrb         (pstrb),
    .prdata        (prdata),
    .pready        (pready),
    .pslverr       (pslverr),
    .rate_drop_evt (rate_drop_evt),
    .drop_evt      (drop_evt),
    .drop_reason   (drop_reason),
    .drop_src      (drop_src),
    .default_vid   (default_vid),
    .default_pri   (default_pri),
    .drop_irq      (drop_irq)
  );

  always #20 clk = ~clk;

  // ==========================================================================
  // reporting
  task complete_run();
    $display("mismatches %0d of %0d compares", err_count, compares);
    if (err_count == 0 && compares > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : complete_run

  task check(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp)
    begin
      err_count++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check

  function automatic logic [31:0] pend_word(input logic [3:0] rb, input logic [1:0] sb,
                                            input logic       vb, input logic [3:0] ra,
                                            input logic [1:0] sa);
    pend_word = {18'h0, rb, sb, vb, ra, sa, 1'b1};
  endfunction : pend_word

  // ==========================================================================
  // apb master; ev pulses rate drops in the setup cycle to hit the clear edge
  task apb(input logic wr, input logic [13:0] idx, input logic [1:0] off,
           input logic [31:0] wd, input logic [2:0] ev);
    int i;
    @(posedge clk);
    psel          <= 1'b1;
    penable       <= 1'b0;
    pwrite        <= wr;
    paddr         <= {idx, off};
    pwdata        <= wd;
    rate_drop_evt <= ev;
    @(posedge clk);
    penable       <= 1'b1;
    rate_drop_evt <= 3'h0;
    // answer is sampled at the rising edge, before the slave updates on it
    for (i = 0; i < 16; i++)
    begin
      @(posedge clk);
      if (pready === 1'b1)
        break;
    end
    if (i == 16)
    begin
      err_count++;
      complete_run();
    end
    rd = prdata;
    er = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task drop(input logic [3:0] r, input logic [1:0] s);
    @(posedge clk);
    drop_evt    <= 1'b1;
    drop_reason <= r;
    drop_src    <= s;
    @(posedge clk);
    drop_evt    <= 1'b0;
  endtask : drop

  // ==========================================================================
  // main sequence
  initial
  begin
    clk = 0; resetn = 0; psel = 0; penable = 0; pwrite = 0; paddr = 16'h0000;
    pwdata = 32'h0; pstrb = 4'hF; rate_drop_evt = 3'h0; drop_evt = 0;
    drop_reason = 4'h0; drop_src = 2'h0; err_count = 0; compares = 0;
    void'($urandom(72555));
    repeat (3) @(posedge clk);
    resetn <= 1'b1;
    for (int p = 0; p < 3; p++)
    begin
      cnt_exp[p] = 32'h0;
      apb(0, switch_tag_drop_pkg::IDX_HOST_TAG + 14'(p), 2'h0, 32'h0, 3'h0);
      check(rd, 32'h0);
      apb(0, switch_tag_drop_pkg::IDX_HOST_CNT + 14'(p), 2'h0, 32'h0, 3'h0);
      check(rd, 32'h0);
    end
    apb(0, switch_tag_drop_pkg::IDX_MASK, 2'h0, 32'h0, 3'h0);
    check(rd, 32'h1);
    apb(0, switch_tag_drop_pkg::IDX_PENDING, 2'h0, 32'h0, 3'h0);
    check(rd, 32'h0);
    // default tags, last one all ones to catch reserved bits leaking
    for (int k = 0; k < 6; k++)
    begin
      d = (k == 5) ? 32'hFFFF_FFFF : $urandom;
      apb(1, switch_tag_drop_pkg::IDX_HOST_TAG + 14'(k % 3), 2'h0, d, 3'h0);
      @(negedge clk);
      check({20'h0, default_vid[k % 3]}, {20'h0, d[11:0]});
      check({29'h0, default_pri[k % 3]}, {29'h0, d[14:12]});
      apb(0, switch_tag_drop_pkg::IDX_HOST_TAG + 14'(k % 3), 2'h0, 32'h0, 3'h0);
      check(rd, d & 32'h0000_7FFF);
    end
    // rate drop counters
    for (int k = 0; k < 4; k++)
    begin
      m = 3'($urandom);
      n = 1 + ($urandom % 20);
      @(posedge clk);
      rate_drop_evt <= m;
      repeat (n) @(posedge clk);
      rate_drop_evt <= 3'h0;
      for (int p = 0; p < 3; p++)
        if (m[p])
          cnt_exp[p] += 32'(n);
    end
    apb(0, switch_tag_drop_pkg::IDX_HOST_CNT, 2'h0, 32'h0, 3'h7);
    check(rd, cnt_exp[0]);
    cnt_exp[0] = 32'h1;
    cnt_exp[1] += 32'h1;
    cnt_exp[2] += 32'h1;
    apb(1, switch_tag_drop_pkg::IDX_PORT1_CNT, 2'h0, $urandom, 3'h0);
    for (int p = 0; p < 3; p++)
    begin
      apb(0, switch_tag_drop_pkg::IDX_HOST_CNT + 14'(p), 2'h0, 32'h0, 3'h0);
      check(rd, cnt_exp[p]);
      apb(0, switch_tag_drop_pkg::IDX_HOST_CNT + 14'(p), 2'h0, 32'h0, 3'h0);
      check(rd, 32'h0);
    end
    // refused addresses
    apb(0, 14'h1C19, 2'h0, 32'h0, 3'h0);
    check({31'h0, er}, 32'h1);
    apb(1, switch_tag_drop_pkg::IDX_PORT2_TAG, 2'h1, 32'h0, 3'h0);
    check({31'h0, er}, 32'h1);
    apb(0, switch_tag_drop_pkg::IDX_PORT2_TAG, 2'h0, 32'h0, 3'h0);
    check({31'h0, er}, 32'h0);
    check(rd, d & 32'h0000_7FFF);
    // only byte lane 1 written: priority and vid bits 11:8 cleared, low byte kept
    @(posedge clk);
    pstrb <= 4'h2;
    apb(1, switch_tag_drop_pkg::IDX_PORT2_TAG, 2'h0, 32'h0, 3'h0);
    @(posedge clk);
    pstrb <= 4'hF;
    apb(0, switch_tag_drop_pkg::IDX_PORT2_TAG, 2'h0, 32'h0, 3'h0);
    check(rd, 32'h0000_00FF);
    // pending status and interrupt; third drop finds both sets full
    r1 = 4'($urandom);
    r2 = 4'($urandom);
    s1 = 2'($urandom % 3);
    s2 = 2'($urandom % 3);
    drop(r1, s1);
    repeat (2) @(negedge clk);
    check({31'h0, drop_irq}, 32'h0);
    drop(r2, s2);
    drop(~r1, s1);
    apb(1, switch_tag_drop_pkg::IDX_MASK, 2'h0, 32'h0, 3'h0);
    repeat (2) @(negedge clk);
    check({31'h0, drop_irq}, 32'h1);
    apb(0, switch_tag_drop_pkg::IDX_MASK, 2'h0, 32'h0, 3'h0);
    check(rd, 32'h0);
    apb(1, switch_tag_drop_pkg::IDX_MASK, 2'h0, 32'h1, 3'h0);
    repeat (2) @(negedge clk);
    check({31'h0, drop_irq}, 32'h0);
    apb(0, switch_tag_drop_pkg::IDX_PENDING, 2'h0, 32'h0, 3'h0);
    check(rd, pend_word(r2, s2, 1'b1, r1, s1));
    apb(0, switch_tag_drop_pkg::IDX_PENDING, 2'h0, 32'h0, 3'h0);
    check(rd, 32'h0);
    apb(1, switch_tag_drop_pkg::IDX_MASK, 2'h0, 32'h0, 3'h0);
    drop(r2, s1);
    repeat (2) @(negedge clk);
    check({31'h0, drop_irq}, 32'h1);
    apb(0, switch_tag_drop_pkg::IDX_PENDING, 2'h0, 32'h0, 3'h0);
    check(rd, pend_word(4'h0, 2'h0, 1'b0, r2, s1));
    repeat (2) @(negedge clk);
    check({31'h0, drop_irq}, 32'h0);
    complete_run();
  end
endmodule : switch_port_default_tag_drop_regs_bench
